/* File: mcs_pkg.sv */
// constants and types for the monitor configuration and sleep control bank
package mcs_pkg;
  // register addresses
  localparam logic [7:0] ADDR_CONFIG = 8'he3;
  localparam logic [7:0] ADDR_SLEEP = 8'he4;
  // configuration register fields
  localparam int CFG_START = 0;
  localparam int CFG_LOCK = 1;
  localparam int CFG_MASK_ALL = 2;
  localparam int CFG_ALERT = 3;
  localparam int CFG_TIE = 4;
  localparam int CFG_READY = 7;
  localparam logic [6:0] CFG_RESET = 7'h00;
  localparam logic [6:0] CFG_WR_FREE = 7'h7c;
  // sleep control fields; upper bits are read-only reserved
  localparam logic [1:0] SLEEP_RESET = 2'h3;
  localparam logic [5:0] SLEEP_RES_HI = 6'h01;
  localparam logic [1:0] SLEEP_S0 = 2'h0;
  localparam logic [1:0] SLEEP_S1 = 2'h1;
  localparam logic [1:0] SLEEP_S3 = 2'h2;
  localparam logic [1:0] SLEEP_S45 = 2'h3;
  localparam logic [7:0] RD_UNMAPPED = 8'h00;

  // one-hot sleep masking mode
  typedef enum logic [3:0] {
    MCS_S0 = 4'b0001,
    MCS_S1 = 4'b0010,
    MCS_S3 = 4'b0100,
    MCS_S45 = 4'b1000
  } mcs_sleep_e;

  // register access request from the serial interface engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mcs_req_s;

  // sleep field to masking mode
  function automatic mcs_sleep_e mcs_decode_sleep(input logic [1:0] field);
    mcs_sleep_e m;
    m = MCS_S0;
    unique case (field)
      SLEEP_S0: m = MCS_S0;
      SLEEP_S1: m = MCS_S1;
      SLEEP_S3: m = MCS_S3;
      SLEEP_S45: m = MCS_S45;
    endcase
    return m;
  endfunction : mcs_decode_sleep
endpackage : mcs_pkg

/* File: mcs_ctrl.sv */
// configuration and sleep state control registers with lock and throttle tie
module mcs_ctrl
  import mcs_pkg::*;
(
  // clock and resets
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ext_reset_in,
  // register access
  input wire mcs_pkg::mcs_req_s req,
  output logic [7:0] rdata,
  output logic rd_valid,
  // measurement side
  input wire logic all_channels_valid,
  // control outputs
  output logic events_masked,
  output logic alert_enable,
  output logic fan_auto_enable,
  output logic pwm_force_zero,
  output logic boost_programmed,
  output mcs_pkg::mcs_sleep_e sleep_mode,
  // open-drain throttle pins, active low
  input wire logic cpu_one_throttle_pin_in,
  output logic cpu_one_throttle_pin_out,
  output logic cpu_one_throttle_pin_oe,
  input wire logic cpu_two_throttle_pin_in,
  output logic cpu_two_throttle_pin_out,
  output logic cpu_two_throttle_pin_oe
);
  import mcs_pkg::*;

  logic [6:0] cfg;
  logic ready;
  logic [1:0] sleep_state_field;
  logic [6:0] next_cfg;
  logic next_ready;
  logic [1:0] next_sleep_state_field;
  logic [7:0] next_rdata;
  logic wr_cfg;
  logic wr_sleep;

  assign wr_cfg = req.wr && (req.addr == ADDR_CONFIG);
  assign wr_sleep = req.wr && (req.addr == ADDR_SLEEP);

  // register next values; external reset overrides any write
  always_comb
  begin
    next_cfg = cfg;
    next_ready = ready | all_channels_valid;
    next_sleep_state_field = sleep_state_field;
    if (wr_cfg)
    begin
      // free bits 2 to 6 stored; start and lock only while unlocked, lock then sticks
      next_cfg = (cfg & ~CFG_WR_FREE) | (req.wdata[6:0] & CFG_WR_FREE);
      if (!cfg[CFG_LOCK])
      begin
        next_cfg[CFG_START] = req.wdata[CFG_START];
        next_cfg[CFG_LOCK] = req.wdata[CFG_LOCK];
      end
      if (cfg[CFG_LOCK])
      begin
        next_cfg[CFG_LOCK] = 1'b1;
      end
    end
    // host tells device its sleep state
    if (wr_sleep)
    begin
      next_sleep_state_field = req.wdata[1:0];
    end
    // external reset forces deepest sleep state
    if (ext_reset_in)
    begin
      next_cfg = CFG_RESET;
      next_ready = 1'b0;
      next_sleep_state_field = SLEEP_S45;
    end
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_rdata = RD_UNMAPPED;
    if (req.addr == ADDR_CONFIG)
    begin
      next_rdata = {ready, cfg};
    end
    else if (req.addr == ADDR_SLEEP)
    begin
      next_rdata = {SLEEP_RES_HI, sleep_state_field};
    end
  end

  // state and outputs; outputs follow next values so they match the registers
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cfg <= CFG_RESET;
      ready <= 1'b0;
      sleep_state_field <= SLEEP_RESET;
      rdata <= RD_UNMAPPED;
      rd_valid <= 1'b0;
      events_masked <= 1'b1;
      alert_enable <= 1'b0;
      fan_auto_enable <= 1'b0;
      pwm_force_zero <= 1'b1;
      boost_programmed <= 1'b0;
      sleep_mode <= MCS_S45;
    end
    else
    begin
      cfg <= next_cfg;
      ready <= next_ready;
      sleep_state_field <= next_sleep_state_field;
      rdata <= next_rdata;
      rd_valid <= req.rd;
      events_masked <= next_cfg[CFG_MASK_ALL] | ~next_cfg[CFG_START];
      alert_enable <= next_cfg[CFG_ALERT];
      // start enables auto fan and programmed boost limits
      fan_auto_enable <= next_cfg[CFG_START];
      pwm_force_zero <= ~next_cfg[CFG_START];
      boost_programmed <= next_cfg[CFG_START];
      sleep_mode <= mcs_decode_sleep(next_sleep_state_field);
    end
  end

  // throttle tie: each pin copies only the other pin's outside low, so the
  // tie itself cannot latch; an external short still latches both low
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cpu_one_throttle_pin_oe <= 1'b0;
      cpu_two_throttle_pin_oe <= 1'b0;
    end
    else
    begin
      cpu_two_throttle_pin_oe <= cfg[CFG_TIE] & ~cpu_one_throttle_pin_in & ~cpu_one_throttle_pin_oe;
      cpu_one_throttle_pin_oe <= cfg[CFG_TIE] & ~cpu_two_throttle_pin_in & ~cpu_two_throttle_pin_oe;
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge ref_clk)
  begin
    cpu_one_throttle_pin_out <= 1'b0;
    cpu_two_throttle_pin_out <= 1'b0;
  end

  // checks
  a_lock_blocks_start: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[CFG_LOCK] && wr_cfg && !ext_reset_in |=> cfg[CFG_START] == $past(cfg[CFG_START]))
    else $error("start changed while locked");
  a_lock_sticky: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[CFG_LOCK] && !ext_reset_in |=> cfg[CFG_LOCK])
    else $error("lock cleared without external reset");
  a_ext_clears_lock: assert property (@(posedge ref_clk) disable iff (rst)
    ext_reset_in |=> !cfg[CFG_LOCK] && !ready)
    else $error("external reset did not clear lock");
  a_global_mask_on: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg[CFG_MASK_ALL] || !cfg[CFG_START]) |->
      events_masked && (cfg[CFG_START] || (pwm_force_zero && !fan_auto_enable && !boost_programmed)))
    else $error("events not masked");
  a_alert_follows: assert property (@(posedge ref_clk) disable iff (rst)
    wr_cfg && !ext_reset_in |=> alert_enable == $past(req.wdata[CFG_ALERT]))
    else $error("alert enable did not follow write");
  a_tie_drives_two: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[CFG_TIE] && !cpu_one_throttle_pin_in && !cpu_one_throttle_pin_oe |=> cpu_two_throttle_pin_oe)
    else $error("tie did not drive second pin");
  a_no_tie_no_drive: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg[CFG_TIE] |=> !cpu_one_throttle_pin_oe && !cpu_two_throttle_pin_oe)
    else $error("throttle pin driven without tie");
  a_ready_sets: assert property (@(posedge ref_clk) disable iff (rst)
    all_channels_valid && !ext_reset_in |=> ready ##1 ready || $past(ext_reset_in))
    else $error("data valid not set");
  a_sleep_decode: assert property (@(posedge ref_clk) disable iff (rst)
    4'(sleep_mode) == (4'h1 << sleep_state_field))
    else $error("sleep mode mismatch");
  a_ext_forces_s45: assert property (@(posedge ref_clk) disable iff (rst)
    ext_reset_in |=> sleep_state_field == SLEEP_S45 && sleep_mode == MCS_S45)
    else $error("external reset did not force S4/5");
  a_start_runs_fan: assert property (@(posedge ref_clk) disable iff (rst)
    cfg[CFG_START] |-> fan_auto_enable && boost_programmed && !pwm_force_zero)
    else $error("start did not enable fan control");

  c_lock_set: cover property (@(posedge ref_clk) disable iff (rst) !cfg[CFG_LOCK] ##1 cfg[CFG_LOCK]);
  c_locked_write: cover property (@(posedge ref_clk) disable iff (rst) cfg[CFG_LOCK] && wr_cfg);
  c_sleep_s1: cover property (@(posedge ref_clk) disable iff (rst) sleep_mode == MCS_S1);
  c_tie_drive: cover property (@(posedge ref_clk) disable iff (rst) cpu_two_throttle_pin_oe);
  c_ready: cover property (@(posedge ref_clk) disable iff (rst) ready && cfg[CFG_START]);
endmodule : mcs_ctrl

/* File: mcs_cpu_model.sv */
// far-side processor throttle drivers on pulled-up open-drain lines
module mcs_cpu_model
(
  // processor throttle requests, high pulls the line low
  input wire logic one_hot,
  input wire logic two_hot,
  // monitor pin drive
  input wire logic one_out,
  input wire logic one_oe,
  input wire logic two_out,
  input wire logic two_oe,
  // resolved line levels
  output logic one_level,
  output logic two_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // lines kept apart, no external short
  assign one_level = ~(one_hot | (one_oe & ~one_out)); // pull-up when released
  assign two_level = ~(two_hot | (two_oe & ~two_out));
endmodule : mcs_cpu_model

/* File: mcs_ctrl_tb.sv */
// self-checking bench for the configuration and sleep control bank
module mcs_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcs_pkg::*;
  logic ref_clk, rst, ext_reset_in, all_channels_valid, one_hot, two_hot;
  mcs_req_s req;
  logic [7:0] rdata;
  logic rd_valid, events_masked, alert_enable, fan_auto_enable, pwm_force_zero, boost_programmed;
  mcs_sleep_e sleep_mode;
  logic one_in, one_out, one_oe, two_in, two_out, two_oe;
  int errors, comparisons;
  mcs_ctrl dut (.ref_clk(ref_clk), .rst(rst), .ext_reset_in(ext_reset_in), .req(req), .rdata(rdata),
    .rd_valid(rd_valid), .all_channels_valid(all_channels_valid), .events_masked(events_masked),
    .alert_enable(alert_enable), .fan_auto_enable(fan_auto_enable), .pwm_force_zero(pwm_force_zero),
    .boost_programmed(boost_programmed), .sleep_mode(sleep_mode), .cpu_one_throttle_pin_in(one_in),
    .cpu_one_throttle_pin_out(one_out), .cpu_one_throttle_pin_oe(one_oe), .cpu_two_throttle_pin_in(two_in),
    .cpu_two_throttle_pin_out(two_out), .cpu_two_throttle_pin_oe(two_oe));
  mcs_cpu_model cpus (.one_hot(one_hot), .two_hot(two_hot), .one_out(one_out), .one_oe(one_oe),
    .two_out(two_out), .two_oe(two_oe), .one_level(one_in), .two_level(two_in));
  // 25 MHz clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // inputs move 1 ns after the edge to stay clear of sampling
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  // requests stay up until the next call or idle, so req never changes twice per step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    cyc(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    cyc(1);
    chk("rd_valid", 8'h01, {7'h00, rd_valid});
    chk("rdata", exp, rdata);
  endtask : rd
  task automatic idle();
    req = '0;
    cyc(1);
  endtask : idle
  // hang guard
  initial
  begin
    repeat (2000) @(posedge ref_clk);
    errors++;
    report_and_stop();
  end
  // main sequence
  initial
  begin
    rst = 1'b1;
    ext_reset_in = 1'b0;
    all_channels_valid = 1'b0;
    one_hot = 1'b0;
    two_hot = 1'b0;
    req = '0;
    errors = 0;
    comparisons = 0;
    cyc(3);
    rst = 1'b0;
    cyc(1);
    rd(ADDR_CONFIG, 8'h00);
    rd(ADDR_SLEEP, 8'h07);
    chk("events_masked", 8'h01, {7'h00, events_masked});
    chk("pwm_force_zero", 8'h01, {7'h00, pwm_force_zero});
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_SLEEP, 8'hfc | 8'(i));
      idle();
      chk("sleep_mode", 8'h01 << i, {4'h0, sleep_mode});
      rd(ADDR_SLEEP, 8'h04 | 8'(i));
    end
    wr(ADDR_CONFIG, 8'h0d);
    idle();
    chk("events_masked", 8'h01, {7'h00, events_masked});
    chk("alert_enable", 8'h01, {7'h00, alert_enable});
    chk("fan_auto_enable", 8'h01, {7'h00, fan_auto_enable});
    chk("boost_programmed", 8'h01, {7'h00, boost_programmed});
    chk("pwm_force_zero", 8'h00, {7'h00, pwm_force_zero});
    chk("rd_valid", 8'h00, {7'h00, rd_valid});
    rd(ADDR_SLEEP, 8'h07);
    wr(ADDR_CONFIG, 8'h01);
    idle();
    chk("events_masked", 8'h00, {7'h00, events_masked});
    chk("alert_enable", 8'h00, {7'h00, alert_enable});
    rd(8'he5, RD_UNMAPPED);
    all_channels_valid = 1'b1;
    cyc(1);
    all_channels_valid = 1'b0;
    // host trusts readings only once data valid reads one
    rd(ADDR_CONFIG, 8'h81);
    wr(ADDR_CONFIG, 8'h11);
    rd(ADDR_CONFIG, 8'h91);
    // tie copies a pulled-low pin to the other, never back
    one_hot = 1'b1;
    idle();
    chk("two_oe", 8'h01, {7'h00, two_oe});
    chk("one_oe", 8'h00, {7'h00, one_oe});
    one_hot = 1'b0;
    cyc(1);
    chk("two_oe", 8'h00, {7'h00, two_oe});
    two_hot = 1'b1;
    cyc(1);
    chk("one_oe", 8'h01, {7'h00, one_oe});
    two_hot = 1'b0;
    cyc(1);
    chk("one_oe", 8'h00, {7'h00, one_oe});
    chk("two_oe", 8'h00, {7'h00, two_oe});
    chk("one_out", 8'h00, {7'h00, one_out});
    chk("two_out", 8'h00, {7'h00, two_out});
    wr(ADDR_CONFIG, 8'h03);
    wr(ADDR_CONFIG, 8'h1c);
    rd(ADDR_CONFIG, 8'h9f);
    wr(ADDR_SLEEP, 8'h00);
    idle();
    ext_reset_in = 1'b1;
    cyc(1);
    ext_reset_in = 1'b0;
    rd(ADDR_CONFIG, 8'h00);
    rd(ADDR_SLEEP, 8'h07);
    chk("sleep_mode", 8'h08, {4'h0, sleep_mode});
    chk("events_masked", 8'h01, {7'h00, events_masked});
    chk("fan_auto_enable", 8'h00, {7'h00, fan_auto_enable});
    chk("pwm_force_zero", 8'h01, {7'h00, pwm_force_zero});
    chk("boost_programmed", 8'h00, {7'h00, boost_programmed});
    wr(ADDR_CONFIG, 8'h01);
    rd(ADDR_CONFIG, 8'h01);
    report_and_stop();
  end
endmodule : mcs_ctrl_tb
